// ### core/lbpp_pins.sv
// Pin controller for the shared 8-bit local bus / parallel port function
// How it works
// - Local bus direction output high while data lines drive, low while receiving.
// - UART clock output at a quarter of the reference clock, switched on and off by enable.
// - Buffered bus clock output, switched on and off by enable.
// - Local bus reset driven both active high and active low together.
// - Four active-low selects: chip selects or data strobes by protocol.
// - Separate-strobe protocol drives active-low write and read strobes.
// - Combined protocol drives read-not-write; read strobe pin left undriven.
// - Eight address outputs and eight bidirectional data lines.
// - Select: open-drain in standard, push-pull address strobe in enhanced.
// - Autofeed: open-drain in standard, push-pull data strobe in enhanced.
// - Latch strobe pulses in standard; low write, high read in enhanced.
// - Initialise driven active low: open-drain standard, push-pull enhanced.
// - Parallel direction output high while data lines drive, low otherwise.
// - Strap selects the function: low local bus, high parallel port.
`timescale 1ns/10ps
`default_nettype none
module lbpp_pins (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    // Mode strap pin and static controls
    input wire logic i_mode_strap,
    input wire logic i_lb_clk_en,
    input wire logic i_uart_clk_en,
    input wire logic i_lb_reset_req,
    input wire logic i_lb_combined_strobe,
    input wire logic i_pp_enhanced,
    input wire logic i_pp_select_in,
    input wire logic i_pp_autofeed,
    input wire logic i_pp_init,
    // Cycle request and answer
    input wire logic i_req_valid,
    input wire logic i_req_write,
    input wire logic [lbpp_pkg::ADDR_W-1:0] i_req_addr,
    input wire logic [lbpp_pkg::DATA_W-1:0] i_req_wdata,
    input wire logic [1:0] i_req_sel,
    output logic o_req_ready,
    output logic o_rsp_valid,
    output logic [lbpp_pkg::DATA_W-1:0] o_rsp_rdata,
    output logic o_mode_pp,
    // Shared data pins
    input wire logic [lbpp_pkg::DATA_W-1:0] i_data_in,
    output logic [lbpp_pkg::DATA_W-1:0] o_data_out,
    output logic o_data_oe,
    output logic o_data_dir,
    // Local bus pins
    output logic o_lb_oe,
    output logic [lbpp_pkg::ADDR_W-1:0] o_lb_addr,
    output logic [lbpp_pkg::NUM_SEL-1:0] o_lb_select_n,
    output logic o_lb_write_strobe_n,
    output logic o_lb_read_strobe_n,
    output logic o_lb_read_strobe_oe,
    output logic o_lb_reset_high,
    output logic o_lb_reset_low,
    output logic o_lb_bus_clock_out,
    output logic o_uart_clk_out,
    // Parallel port pins
    input wire logic i_pp_ack_n,
    input wire logic i_pp_busy,
    input wire logic i_pp_paper_out,
    input wire logic i_pp_selected,
    input wire logic i_pp_error_n,
    output logic o_pp_select_in_n,
    output logic o_pp_select_in_oe,
    output logic o_pp_autofeed_n,
    output logic o_pp_autofeed_oe,
    output logic o_pp_latch_strobe_n,
    output logic o_pp_latch_strobe_oe,
    output logic o_pp_init_n,
    output logic o_pp_init_oe,
    output logic [lbpp_pkg::STATUS_W-1:0] o_pp_status,
    output logic o_pp_irq_event
);
    // ------------------------------------------------------------------
    // Pin synchronisers and mode strap
    // ------------------------------------------------------------------
    logic [lbpp_pkg::SYNC_W-1:0] meta_q;
    logic [lbpp_pkg::SYNC_W-1:0] sync_q;
    logic ack_prev_q;
    logic captured_q;
    logic mode_pp_q;
    logic [1:0] settle_q;
    wire [lbpp_pkg::SYNC_W-1:0] pin_in = {i_mode_strap, i_pp_error_n, i_pp_selected,
                                          i_pp_paper_out, i_pp_busy, i_pp_ack_n, i_data_in};
    wire [lbpp_pkg::DATA_W-1:0] data_s = sync_q[lbpp_pkg::DATA_W-1:0];
    wire [lbpp_pkg::STATUS_W-1:0] status_s = sync_q[lbpp_pkg::SYNC_W-2:lbpp_pkg::DATA_W];
    wire strap_s = sync_q[lbpp_pkg::SYNC_W-1];
    wire busy_s = status_s[lbpp_pkg::ST_BUSY];

    // Two-flop capture of every pin input; strap caught once both stages hold it
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            meta_q <= '0;
            sync_q <= '0;
            settle_q <= '0;
            captured_q <= 1'b0;
            mode_pp_q <= lbpp_pkg::RST_MODE_PP;
        end
        else
        begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            settle_q <= {settle_q[0], 1'b1};
            if (!captured_q && settle_q[1])
            begin
                captured_q <= 1'b1;
                mode_pp_q <= strap_s;
            end
        end
    end

    // ------------------------------------------------------------------
    // Request capture and sequencer
    // ------------------------------------------------------------------
    lbpp_seq_if seq_if();
    logic ready_q;
    logic [lbpp_pkg::ADDR_W-1:0] addr_q;
    logic [lbpp_pkg::DATA_W-1:0] wdata_q;
    logic [1:0] sel_q;
    logic write_q;
    wire lb_en = captured_q & ~mode_pp_q;
    wire pp_en = captured_q & mode_pp_q;
    wire enhanced_port_mode = pp_en & i_pp_enhanced;
    wire standard_printer_mode = pp_en & ~i_pp_enhanced;
    // Peripheral flow control gates the start of a cycle
    wire gate_ok = ~(standard_printer_mode & i_req_write & busy_s) & ~(enhanced_port_mode & busy_s);
    wire take = i_req_valid & ready_q;
    wire ready_d = captured_q & ~seq_if.busy & ~take & gate_ok;

    assign seq_if.start = take;
    assign seq_if.write = i_req_write;
    assign seq_if.use_wait = enhanced_port_mode;
    assign seq_if.wait_n = busy_s;

    lbpp_strobe_seq u_seq (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .bus(seq_if)
    );

    // Cycle fields held for the whole cycle
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            addr_q <= '0;
            wdata_q <= '0;
            sel_q <= '0;
            write_q <= 1'b0;
        end
        else if (take)
        begin
            addr_q <= i_req_addr;
            wdata_q <= i_req_wdata;
            sel_q <= i_req_sel;
            write_q <= i_req_write;
        end
    end

    // ------------------------------------------------------------------
    // Pin decode
    // ------------------------------------------------------------------
    wire in_cyc = seq_if.busy;
    wire drive_d = seq_if.drive & captured_q;
    wire [lbpp_pkg::NUM_SEL-1:0] sel_dec = lbpp_pkg::NUM_SEL'(1) << sel_q;
    // Chip select covers the cycle; data strobe only the strobe phase
    wire sel_act = i_lb_combined_strobe ? seq_if.strobe : in_cyc;
    wire [lbpp_pkg::NUM_SEL-1:0] select_n_d = (lb_en & sel_act) ? ~sel_dec
                                                                 : lbpp_pkg::RST_SELECT_N;
    wire lb_read_not_write = ~(in_cyc & write_q);
    wire wr_n_d = i_lb_combined_strobe ? lb_read_not_write
                                       : ~(seq_if.strobe & write_q);
    wire rd_n_d = ~(seq_if.strobe & ~write_q);
    wire rd_oe_d = lb_en & ~i_lb_combined_strobe;
    wire lb_rst_d = ~captured_q | i_lb_reset_req;
    wire addr_cyc = seq_if.strobe & addr_q[0];
    wire data_cyc = seq_if.strobe & ~addr_q[0];
    // Open-drain in standard mode pulls low by enabling; enhanced drives both ways
    wire sel_n_d = enhanced_port_mode ? ~addr_cyc : 1'b0;
    wire sel_oe_d = enhanced_port_mode | (standard_printer_mode & i_pp_select_in);
    wire afd_n_d = enhanced_port_mode ? ~data_cyc : 1'b0;
    wire afd_oe_d = enhanced_port_mode | (standard_printer_mode & i_pp_autofeed);
    wire stb_n_d = enhanced_port_mode ? ~(in_cyc & write_q) : 1'b0;
    wire stb_oe_d = enhanced_port_mode | (standard_printer_mode & seq_if.strobe & write_q);
    wire init_n_d = enhanced_port_mode ? ~i_pp_init : 1'b0;
    wire init_oe_d = enhanced_port_mode | (standard_printer_mode & i_pp_init);

    // ------------------------------------------------------------------
    // Buffered clocks
    // ------------------------------------------------------------------
    logic [lbpp_pkg::UART_DIV_W-1:0] div_q;
    wire div_tick = (div_q == lbpp_pkg::UART_DIV_W'(lbpp_pkg::UART_CLK_DIV - 1));

    // Divider making the UART clock enable pulse
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            div_q <= '0;
        else
            div_q <= div_tick ? '0 : div_q + 1'b1;
    end

    // ------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            ready_q <= 1'b0;
            o_rsp_valid <= 1'b0;
            o_rsp_rdata <= '0;
            o_data_out <= '0;
            o_data_oe <= 1'b0;
            o_data_dir <= 1'b0;
            o_lb_oe <= 1'b0;
            o_lb_addr <= '0;
            o_lb_select_n <= lbpp_pkg::RST_SELECT_N;
            o_lb_write_strobe_n <= 1'b1;
            o_lb_read_strobe_n <= 1'b1;
            o_lb_read_strobe_oe <= 1'b0;
            o_lb_reset_high <= 1'b1;
            o_lb_reset_low <= 1'b0;
            o_lb_bus_clock_out <= 1'b0;
            o_uart_clk_out <= 1'b0;
            o_pp_select_in_n <= 1'b0;
            o_pp_select_in_oe <= 1'b0;
            o_pp_autofeed_n <= 1'b0;
            o_pp_autofeed_oe <= 1'b0;
            o_pp_latch_strobe_n <= 1'b0;
            o_pp_latch_strobe_oe <= 1'b0;
            o_pp_init_n <= 1'b0;
            o_pp_init_oe <= 1'b0;
            o_pp_status <= '0;
            o_pp_irq_event <= 1'b0;
            ack_prev_q <= 1'b1;
        end
        else
        begin
            ready_q <= ready_d;
            o_rsp_valid <= seq_if.done;
            if (seq_if.sample)
                o_rsp_rdata <= data_s;
            o_data_out <= wdata_q;
            o_data_oe <= drive_d;
            o_data_dir <= drive_d;
            o_lb_oe <= lb_en;
            o_lb_addr <= addr_q;
            o_lb_select_n <= select_n_d;
            o_lb_write_strobe_n <= wr_n_d;
            o_lb_read_strobe_n <= rd_n_d;
            o_lb_read_strobe_oe <= rd_oe_d;
            o_lb_reset_high <= lb_rst_d;
            o_lb_reset_low <= ~lb_rst_d;
            if (i_lb_clk_en && lb_en)
                o_lb_bus_clock_out <= ~o_lb_bus_clock_out;
            if (i_uart_clk_en && lb_en && div_tick)
                o_uart_clk_out <= ~o_uart_clk_out;
            o_pp_select_in_n <= sel_n_d;
            o_pp_select_in_oe <= sel_oe_d;
            o_pp_autofeed_n <= afd_n_d;
            o_pp_autofeed_oe <= afd_oe_d;
            o_pp_latch_strobe_n <= stb_n_d;
            o_pp_latch_strobe_oe <= stb_oe_d;
            o_pp_init_n <= init_n_d;
            o_pp_init_oe <= init_oe_d;
            o_pp_status <= status_s;
            // Falling acknowledge marks a finished transfer or interrupt
            ack_prev_q <= status_s[lbpp_pkg::ST_ACK_N];
            o_pp_irq_event <= pp_en & ack_prev_q & ~status_s[lbpp_pkg::ST_ACK_N];
        end
    end

    assign o_req_ready = ready_q;
    assign o_mode_pp = mode_pp_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_reset_n);

    property p_dir_with_oe;
        o_data_dir == o_data_oe;
    endproperty
    a_dir_with_oe: assert property (p_dir_with_oe)
        else $error("Direction output differs from data enable");
    property p_reset_pair;
        o_lb_reset_high != o_lb_reset_low;
    endproperty
    a_reset_pair: assert property (p_reset_pair)
        else $error("Reset outputs not complementary");
    property p_read_hiz;
        (lb_en && i_lb_combined_strobe) |=> !o_lb_read_strobe_oe;
    endproperty
    a_read_hiz: assert property (p_read_hiz)
        else $error("Read strobe driven in combined protocol");
    property p_clk_off;
        !i_lb_clk_en |=> $stable(o_lb_bus_clock_out);
    endproperty
    a_clk_off: assert property (p_clk_off)
        else $error("Bus clock toggled while disabled");
    property p_uart_off;
        !i_uart_clk_en |=> $stable(o_uart_clk_out);
    endproperty
    a_uart_off: assert property (p_uart_off)
        else $error("UART clock toggled while disabled");
    property p_one_select;
        $countones(~o_lb_select_n) <= 1;
    endproperty
    a_one_select: assert property (p_one_select)
        else $error("More than one select asserted");
    property p_epp_pushpull;
        enhanced_port_mode |=> (o_pp_select_in_oe && o_pp_autofeed_oe && o_pp_init_oe);
    endproperty
    a_epp_pushpull: assert property (p_epp_pushpull)
        else $error("Enhanced mode output not driven");
    property p_mode_stable;
        (captured_q && $past(captured_q)) |-> $stable(mode_pp_q);
    endproperty
    a_mode_stable: assert property (p_mode_stable)
        else $error("Function mode changed after capture");
endmodule
`default_nettype wire

// ### core/lbpp_pkg.sv
// Shared constants and types for the local bus / parallel port pin block
package lbpp_pkg;

    // ------------------------------------------------------------------
    // Clock and cycle timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETUP_NS = 30;
    localparam int STROBE_NS = 60;
    localparam int HOLD_NS = 30;
    localparam int WAIT_TIMEOUT_NS = 10000;
    // Least times round up to whole cycles
    localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Longest time rounds down
    localparam int WAIT_TIMEOUT_CYC = WAIT_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 10;
    localparam int UART_CLK_DIV = 2;
    localparam int UART_DIV_W = 4;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int NUM_SEL = 4;
    localparam int STATUS_W = 5;
    localparam int SYNC_W = 14;
    localparam logic RST_MODE_PP = 1'b0;
    localparam logic [NUM_SEL-1:0] RST_SELECT_N = 4'hf;

    // Parallel status field positions
    localparam int ST_ACK_N = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_PAPER = 2;
    localparam int ST_SELECTED = 3;
    localparam int ST_ERROR_N = 4;

    // ------------------------------------------------------------------
    // Strobe sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        SEQ_IDLE = 4'h1,
        SEQ_SETUP = 4'h2,
        SEQ_STROBE = 4'h4,
        SEQ_HOLD = 4'h8
    } lbpp_seq_state_t;

endpackage

// ### core/lbpp_seq_if.sv
// Control link between the pin controller and its strobe sequencer
`timescale 1ns/10ps
`default_nettype none
interface lbpp_seq_if;
    logic start;
    logic write;
    logic use_wait;
    logic wait_n;
    logic busy;
    logic drive;
    logic strobe;
    logic sample;
    logic done;
    modport ctl(output start, write, use_wait, wait_n, input busy, drive, strobe, sample, done);
    modport seq(input start, write, use_wait, wait_n, output busy, drive, strobe, sample, done);
endinterface
`default_nettype wire

// ### core/lbpp_strobe_seq.sv
// Setup / strobe / hold sequencer shared by local bus and parallel cycles
`timescale 1ns/10ps
`default_nettype none
module lbpp_strobe_seq (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    // Controller link
    lbpp_seq_if.seq bus
);
    lbpp_pkg::lbpp_seq_state_t state_q;
    lbpp_pkg::lbpp_seq_state_t state_d;
    logic [lbpp_pkg::CNT_W-1:0] cnt_q;
    logic [lbpp_pkg::CNT_W-1:0] cnt_d;
    logic write_q;
    logic wait_q;
    wire cnt_zero = (cnt_q == '0);
    // Handshake end: peripheral raises its wait line, or timeout
    wire strobe_end = cnt_zero | (wait_q & bus.wait_n);

    // Next state and phase counter
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        unique case (state_q)
            lbpp_pkg::SEQ_IDLE:
            begin
                if (bus.start)
                begin
                    state_d = lbpp_pkg::SEQ_SETUP;
                    cnt_d = lbpp_pkg::CNT_W'(lbpp_pkg::SETUP_CYC - 1);
                end
            end
            lbpp_pkg::SEQ_SETUP:
            begin
                if (cnt_zero)
                begin
                    state_d = lbpp_pkg::SEQ_STROBE;
                    cnt_d = wait_q ? lbpp_pkg::CNT_W'(lbpp_pkg::WAIT_TIMEOUT_CYC - 1)
                                   : lbpp_pkg::CNT_W'(lbpp_pkg::STROBE_CYC - 1);
                end
                else
                    cnt_d = cnt_q - 1'b1;
            end
            lbpp_pkg::SEQ_STROBE:
            begin
                if (strobe_end)
                begin
                    state_d = lbpp_pkg::SEQ_HOLD;
                    cnt_d = lbpp_pkg::CNT_W'(lbpp_pkg::HOLD_CYC - 1);
                end
                else
                    cnt_d = cnt_q - 1'b1;
            end
            lbpp_pkg::SEQ_HOLD:
            begin
                if (cnt_zero)
                    state_d = lbpp_pkg::SEQ_IDLE;
                else
                    cnt_d = cnt_q - 1'b1;
            end
            default:
                state_d = lbpp_pkg::SEQ_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_q <= lbpp_pkg::SEQ_IDLE;
            cnt_q <= '0;
            write_q <= 1'b0;
            wait_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            if (bus.start && state_q == lbpp_pkg::SEQ_IDLE)
            begin
                write_q <= bus.write;
                wait_q <= bus.use_wait;
            end
        end
    end

    // Phase outputs
    assign bus.busy = (state_q != lbpp_pkg::SEQ_IDLE);
    assign bus.drive = write_q & (state_q != lbpp_pkg::SEQ_IDLE);
    assign bus.strobe = (state_q == lbpp_pkg::SEQ_STROBE);
    assign bus.sample = bus.strobe & strobe_end & ~write_q;
    assign bus.done = (state_q == lbpp_pkg::SEQ_HOLD) & cnt_zero;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_setup;
        (state_q == lbpp_pkg::SEQ_SETUP) [*3];
    endsequence
    sequence s_strobe;
        (state_q == lbpp_pkg::SEQ_STROBE);
    endsequence
    property p_setup_then_strobe;
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        (state_q == lbpp_pkg::SEQ_IDLE && bus.start) |=> s_setup ##1 s_strobe;
    endproperty
    a_setup_then_strobe: assert property (p_setup_then_strobe)
        else $error("Cycle setup phase length wrong");
    property p_strobe_bounded;
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        ($rose(bus.strobe) && !wait_q) |-> ##[1:6] (state_q == lbpp_pkg::SEQ_HOLD);
    endproperty
    a_strobe_bounded: assert property (p_strobe_bounded)
        else $error("Fixed strobe did not end in time");
endmodule
`default_nettype wire

// ### test/lbpp_periph.sv
// Behavioural peripheral on the far side of the shared pins
`timescale 1ns/10ps
`default_nettype none
module lbpp_periph #(
    parameter logic [7:0] RD_BYTE = 8'ha5
) (
    // Clock and mode
    input wire logic i_ref_clk,
    input wire logic i_epp,
    // Pins from the device
    input wire logic i_data_oe,
    input wire logic [7:0] i_data_out,
    input wire logic i_rd_n,
    input wire logic i_strobe_n,
    input wire logic i_latch_n,
    // Behaviour set by the bench
    input wire logic i_busy_lvl,
    input wire logic [3:0] i_delay,
    input wire logic i_no_paper,
    // Pins toward the device
    output logic [7:0] o_data_in,
    output logic o_ack_n,
    output logic o_busy,
    output logic o_paper_out,
    output logic o_selected,
    output logic o_error_n
);
    logic [7:0] last_q = 8'h00;
    logic [3:0] wait_q = 4'h0;
    logic [2:0] ack_q = 3'h0;
    logic latch_q = 1'b1;
    // Strobe length, latch edge and last bus level
    always_ff @(posedge i_ref_clk)
    begin
        last_q <= o_data_in;
        latch_q <= i_latch_n;
        wait_q <= i_strobe_n ? 4'h0 : wait_q + {3'h0, wait_q != 4'hf};
        ack_q <= (i_latch_n && !latch_q) ? 3'h4 : ack_q - {2'h0, ack_q != 3'h0};
    end
    // Released lines show the inverse of the last level, or RD_BYTE while read
    assign o_data_in = i_data_oe ? i_data_out : (i_rd_n ? ~last_q : RD_BYTE);
    assign o_ack_n = (ack_q == 3'h0);
    assign o_busy = i_epp ? (!i_strobe_n && wait_q >= i_delay) : i_busy_lvl;
    assign {o_paper_out, o_selected, o_error_n} = {i_no_paper, 1'b1, !i_no_paper};
endmodule
`default_nettype wire

// ### test/lbpp_pins_tb.sv
// Self-checking bench for the local bus / parallel port pin block
`timescale 1ns/10ps
`default_nettype none
module lbpp_pins_tb;
    logic i_ref_clk = 1'b0, i_reset_n = 1'b0, i_mode_strap = 1'b0, i_lb_clk_en = 1'b0;
    logic i_uart_clk_en = 1'b0, i_lb_reset_req = 1'b0, i_lb_combined_strobe = 1'b0;
    logic i_pp_enhanced = 1'b0, i_pp_select_in = 1'b0, i_pp_autofeed = 1'b0, i_pp_init = 1'b0;
    logic i_req_valid = 1'b0, i_req_write = 1'b0, busy_lvl = 1'b0, no_paper = 1'b0, mon = 1'b0;
    logic [7:0] i_req_addr = 8'h00, i_req_wdata = 8'h00, i_data_in, o_rsp_rdata, o_data_out;
    logic [7:0] o_lb_addr, seen_a, seen_d;
    logic [1:0] i_req_sel = 2'h0, clk_q;
    logic [3:0] dly = 4'h3, o_lb_select_n, seen_s;
    logic [4:0] o_pp_status;
    logic i_pp_ack_n, i_pp_busy, i_pp_paper_out, i_pp_selected, i_pp_error_n, o_req_ready;
    logic o_rsp_valid, o_mode_pp, o_data_oe, o_data_dir, o_lb_oe, o_lb_write_strobe_n;
    logic o_lb_read_strobe_n, o_lb_read_strobe_oe, o_lb_reset_high, o_lb_reset_low, o_pp_irq_event;
    logic o_lb_bus_clock_out, o_uart_clk_out, o_pp_select_in_n, o_pp_select_in_oe, o_pp_autofeed_n;
    logic o_pp_autofeed_oe, o_pp_latch_strobe_n, o_pp_latch_strobe_oe, o_pp_init_n, o_pp_init_oe;
    int cnt[11];
    int mismatches = 0, n_tests = 0, cyc = 0, dirbad = 0;
    // Open-drain wire levels with pull-ups, and the peripheral's read enable
    wire sel_w = o_pp_select_in_oe ? o_pp_select_in_n : 1'b1;
    wire af_w = o_pp_autofeed_oe ? o_pp_autofeed_n : 1'b1;
    wire lat_w = o_pp_latch_strobe_oe ? o_pp_latch_strobe_n : 1'b1;
    wire lb_rd_n = o_lb_read_strobe_oe ? o_lb_read_strobe_n : &o_lb_select_n | !o_lb_write_strobe_n;
    wire rd_n = o_lb_oe ? lb_rd_n : sel_w & af_w;
    lbpp_pins lbpp_pins_inst (.*);
    lbpp_periph lbpp_periph_inst (.i_ref_clk(i_ref_clk), .i_epp(i_pp_enhanced),
        .i_data_oe(o_data_oe), .i_data_out(o_data_out), .i_rd_n(rd_n), .i_strobe_n(sel_w & af_w),
        .i_latch_n(lat_w), .i_busy_lvl(busy_lvl), .i_delay(dly), .i_no_paper(no_paper),
        .o_data_in(i_data_in), .o_ack_n(i_pp_ack_n), .o_busy(i_pp_busy),
        .o_paper_out(i_pp_paper_out), .o_selected(i_pp_selected), .o_error_n(i_pp_error_n));
    // Clock
    initial
    begin
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    // Pin activity counters and hang limit
    always @(posedge i_ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            mismatches++;
            test_done();
        end
        dirbad += int'(o_data_dir !== o_data_oe);
        clk_q <= {o_lb_bus_clock_out, o_uart_clk_out};
        if (mon)
        begin
            cnt[0] += int'(o_lb_write_strobe_n === 1'b0 && o_lb_select_n !== 4'hf);
            cnt[1] += int'(o_lb_read_strobe_n === 1'b0 && o_lb_read_strobe_oe === 1'b1);
            cnt[2] += int'(o_lb_select_n !== 4'hf);
            cnt[3] += int'(o_lb_read_strobe_oe === 1'b1);
            cnt[4] += int'(lat_w === 1'b0);
            cnt[5] += int'(sel_w === 1'b0);
            cnt[6] += int'(af_w === 1'b0);
            cnt[7] += int'(o_pp_irq_event === 1'b1);
            cnt[8] += int'(o_lb_bus_clock_out !== clk_q[1]);
            cnt[9] += int'(o_uart_clk_out !== clk_q[0]);
            cnt[10] += int'(o_rsp_valid === 1'b1);
            if (o_data_oe === 1'b1) {seen_a, seen_d} = {o_lb_addr, o_data_out};
            if (o_lb_select_n !== 4'hf) seen_s = o_lb_select_n;
        end
    end
    task automatic tick(input int n = 1);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wait_ready();
        int k = 0;
        while (o_req_ready !== 1'b1 && k < 2000)
        begin
            tick();
            k++;
        end
        chk("ready", k < 2000, 1'b1);
    endtask
    // One request, held until taken, watched until the pins settle again
    task automatic xfer(input logic w, input logic [7:0] a, d, input logic [1:0] s);
        wait_ready();
        cnt = '{default: 0};
        {i_req_valid, i_req_write, i_req_addr, i_req_wdata, i_req_sel} = {1'b1, w, a, d, s};
        mon = 1'b1;
        tick();
        i_req_valid = 1'b0;
        wait_ready();
        tick(6);
        mon = 1'b0;
    endtask
    task automatic do_reset(input logic strap);
        {i_reset_n, i_mode_strap} = {1'b0, strap};
        tick(4);
        chk("reset_pair", {o_lb_reset_high, o_lb_reset_low, o_lb_select_n}, 6'h2f);
        i_reset_n = 1'b1;
        wait_ready();
        chk("mode", {o_mode_pp, o_lb_oe}, {strap, !strap});
    endtask
    task automatic t_lb_sep();
        i_lb_reset_req = 1'b1;
        tick(3);
        chk("reset_req", {o_lb_reset_high, o_lb_reset_low}, 2'b10);
        i_lb_reset_req = 1'b0;
        xfer(1'b1, 8'h3c, 8'h96, 2'd2);
        chk("reset_off", {o_lb_reset_high, o_lb_reset_low}, 2'b01);
        chk("wr_strobe", cnt[10] * 256 + cnt[0] * 16 + cnt[1], 16'h160);
        chk("sel_wr", seen_s, 4'hb);
        chk("addr_data", seen_a ^ seen_d, 8'haa);
        xfer(1'b0, 8'hc3, 8'h00, 2'd3);
        chk("rd_strobe", cnt[0] * 16 + cnt[1], 8'h06);
        chk("rd_data", {seen_s, o_rsp_rdata}, 12'h7a5);
    endtask
    task automatic t_lb_comb();
        i_lb_combined_strobe = 1'b1;
        tick(2);
        xfer(1'b0, 8'h11, 8'h00, 2'd0);
        chk("rd_hiz", cnt[3] * 16 + cnt[0], 0);
        chk("comb_rdata", o_rsp_rdata, 8'ha5);
        xfer(1'b1, 8'h22, 8'h5a, 2'd1);
        chk("rnw_write", cnt[0] * 16 + seen_s, 8'h6d);
        i_lb_combined_strobe = 1'b0;
    endtask
    task automatic t_clocks();
        for (int e = 1; e >= 0; e--)
        begin
            {i_lb_clk_en, i_uart_clk_en} = {2{e[0]}};
            tick(4);
            cnt = '{default: 0};
            mon = 1'b1;
            tick(20);
            mon = 1'b0;
            chk("clk_toggles", cnt[8] * 64 + cnt[9], e * 1280 + e * 20 / lbpp_pkg::UART_CLK_DIV);
        end
    endtask
    task automatic t_spp();
        {i_pp_select_in, i_pp_init, no_paper, busy_lvl} = 4'hf;
        tick(4);
        chk("open_drain", {o_pp_select_in_oe, o_pp_select_in_n, o_pp_autofeed_oe}, 3'h4);
        chk("init_od", {o_pp_init_oe, o_pp_init_n}, 2'b10);
        chk("busy_status", {o_req_ready, o_pp_status}, 6'h0f);
        busy_lvl = 1'b0;
        xfer(1'b1, 8'h00, 8'h69, 2'd0);
        chk("latch_pulse", cnt[4], 6);
        chk("ack_event", {cnt[7], seen_d}, 9'h169);
    endtask
    task automatic t_epp();
        i_pp_enhanced = 1'b1;
        tick(4);
        chk("push_pull", {o_pp_select_in_oe, o_pp_autofeed_oe, o_pp_init_oe, o_pp_init_n}, 4'he);
        dly = 4'h1;
        xfer(1'b1, 8'h01, 8'h42, 2'd0);
        chk("addr_cycle", {cnt[5] != 0, cnt[6] != 0, cnt[4] != 0}, 3'h5);
        chk("epp_wdata", seen_d, 8'h42);
        dly = 4'h9;
        xfer(1'b0, 8'h00, 8'h00, 2'd0);
        chk("data_cycle", {cnt[5] != 0, cnt[6] != 0, cnt[4] != 0}, 3'h2);
        chk("epp_rdata", o_rsp_rdata, 8'ha5);
    endtask
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        do_reset(1'b0);
        t_lb_sep();
        t_lb_comb();
        t_clocks();
        do_reset(1'b1);
        t_spp();
        t_epp();
        chk("dir_follow", dirbad, 0);
        test_done();
    end
endmodule
`default_nettype wire
